/* File: src/pst_pkg.sv */
// Purpose: Shared constants for the power state stepper.
// Assumes: One 40 MHz clock, AXI4-Lite register access.
// Notes:   Register offsets are byte addresses of aligned words.
package pst_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 40_000_000;
  localparam int DEBOUNCE_US  = 5000;
  localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
  localparam int CNT_W        = 18;

  // ----------------------------------------------------------------
  // Buttons, states and load
  // ----------------------------------------------------------------
  localparam int NUM_BTN       = 4;
  localparam int BTN_RST       = 0;
  localparam int BTN_FREQ      = 1;
  localparam int BTN_UTIL      = 2;
  localparam int BTN_PIN       = 3;
  localparam int FREQ_W        = 2;
  localparam int UTIL_W        = 5;
  localparam int NUM_UNITS     = 20;
  localparam int PINS_PER_UNIT = 8;
  localparam int NUM_PINS      = NUM_UNITS * PINS_PER_UNIT;
  localparam logic [FREQ_W-1:0] FREQ_MAX = 2'h3;
  localparam logic [UTIL_W-1:0] UTIL_MAX = 5'h13;
  localparam logic [FREQ_W-1:0] FREQ_RST = 2'h0;
  localparam logic [UTIL_W-1:0] UTIL_RST = 5'h00;
  localparam logic              OUTEN_RST = 1'h0;

  // Pace accumulator steps: stopped, one third, two thirds, full rate.
  localparam int PACE_W = 9;
  localparam logic [3:0][PACE_W-1:0] PACE_STEP =
    {9'h100, 9'h0ab, 9'h055, 9'h000};

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_STATE  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam int ST_FREQ_LSB  = 0;
  localparam int ST_UTIL_LSB  = 4;
  localparam int ST_OUTEN_BIT = 12;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pst_pkg

/* File: src/pst_load_unit.sv */
// Purpose: One replicated load slice with shift register, ROM, multiply.
// Assumes: advance pulses mark the slice's own pace.
// Notes:   Read data of the ROM leaves through a register.
`timescale 1ns/1ps
module pst_load_unit #(
  parameter logic [15:0] Seed = 16'h1
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       advance,
  input  wire logic       drive,
  // Pins
  output logic [7:0]      pinData
);
  import pst_pkg::*;

  typedef struct packed {
    logic [15:0] shift;
    logic [7:0]  romData;
    logic [15:0] product;
    logic [7:0]  pins;
  } pst_unit_t;

  pst_unit_t r;
  pst_unit_t n;

  function automatic logic [7:0] romLookup(input logic [3:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      4'h0: d = 8'h3c;  4'h1: d = 8'ha5;  4'h2: d = 8'h5e;  4'h3: d = 8'h91;
      4'h4: d = 8'h07;  4'h5: d = 8'hd2;  4'h6: d = 8'h6b;  4'h7: d = 8'he8;
      4'h8: d = 8'h14;  4'h9: d = 8'hc7;  4'ha: d = 8'h7f;  4'hb: d = 8'h2a;
      4'hc: d = 8'hb9;  4'hd: d = 8'h40;  4'he: d = 8'hf3;  default: d = 8'h86;
    endcase
    return d;
  endfunction : romLookup

  // ----------------------------------------------------------------
  // Load datapath
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    if (advance) begin
      n.shift   = {r.shift[14:0],
                   r.shift[15] ^ r.shift[13] ^ r.shift[12] ^ r.shift[10]};
      n.romData = romLookup(r.shift[3:0]);
      n.product = r.romData * r.shift[15:8];
      n.pins    = r.product[7:0] ^ r.product[15:8];
    end
    if (!drive) begin
      n.pins = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '{shift: Seed, romData: 8'h00, product: 16'h0000, pins: 8'h00};
    end else begin
      r <= n;
    end
  end

  assign pinData = r.pins;

endmodule : pst_load_unit

/* File: src/pst_stepper.sv */
// Purpose: Button-driven power state stepper with replicated load.
// Assumes: Buttons are active low and asynchronous to core_clk.
// Notes:   Software sees and sets the states over AXI4-Lite.
//
// How it works
// - Everything runs on one input clock.
// - Reset button clears frequency, resource, enable.
// - Frequency button steps frequency state up.
// - Resource button steps resource state up.
// - Output button toggles the output enable.
// - Two LEDs show frequency state code.
// - Five LEDs show resource state code.
// - Resource state sets eight pins per step.
// - Frequency state sets pin toggle rate.
// - Active-low lamp lit while outputs enabled.
// - Load slices up to the resource state shift every paced cycle.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module pst_stepper #(
  parameter int DebounceCycles = pst_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  // Push buttons
  input  wire logic                         resetButtonN,
  input  wire logic                         freqButtonN,
  input  wire logic                         utilButtonN,
  input  wire logic                         pinToggleButtonN,
  // Indicator LEDs
  output logic                              freqIndicatorBit0,
  output logic                              freqIndicatorBit1,
  output logic [pst_pkg::UTIL_W-1:0]        utilIndicator,
  output logic                              pinToggleLampN,
  // Load pins
  output logic [pst_pkg::NUM_PINS-1:0]      loadPins,
  // AXI4-Lite write address
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [pst_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // AXI4-Lite write response
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [pst_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  // AXI4-Lite read data
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp
);
  import pst_pkg::*;

  // Last count of a stable level before the debounced output follows it.
  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DebounceCycles - 1);

  // All registers of the stepper, held in one word.
  typedef struct packed {
    logic [NUM_BTN-1:0]            sync1;
    logic [NUM_BTN-1:0]            sync2;
    logic [NUM_BTN-1:0]            deb;
    logic [NUM_BTN-1:0][CNT_W-1:0] cnt;
    logic [FREQ_W-1:0]             freq;
    logic [UTIL_W-1:0]             util;
    logic                          outEn;
    logic [PACE_W-2:0]             pace;
    logic                          paceHit;
    logic                          awHave;
    logic [ADDR_W-1:0]             awAddr;
    logic                          wHave;
    logic [31:0]                   wData;
    logic [3:0]                    wStrb;
    logic                          bValid;
    logic [1:0]                    bResp;
    logic                          rValid;
    logic [31:0]                   rData;
    logic [1:0]                    rResp;
  } pst_state_t;

  pst_state_t r;
  pst_state_t n;

  logic [NUM_BTN-1:0]           btnRaw;
  logic [NUM_BTN-1:0]           press;
  logic [NUM_UNITS-1:0]         unitOn;

  // Register that a bus address selects.
  typedef enum logic [1:0] {
    SEL_STATE,
    SEL_STATUS,
    SEL_NONE
  } pst_sel_t;

  // Maps a byte address onto the register that it selects.
  function automatic pst_sel_t regDecode(input logic [ADDR_W-1:0] a);
    pst_sel_t s;
    if (a == REG_STATE) begin
      s = SEL_STATE;
    end else if (a == REG_STATUS) begin
      s = SEL_STATUS;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction : regDecode

  // Packs the three state fields into the layout of the state register.
  function automatic logic [31:0] stateWord(
    input logic [FREQ_W-1:0] f,
    input logic [UTIL_W-1:0] u,
    input logic              o
  );
    logic [31:0] w;
    w                        = 32'h0000_0000;
    w[ST_FREQ_LSB +: FREQ_W] = f;
    w[ST_UTIL_LSB +: UTIL_W] = u;
    w[ST_OUTEN_BIT]          = o;
    return w;
  endfunction : stateWord

  // Reports the debounced button levels with a pressed button as one.
  function automatic logic [31:0] statusWord(
    input logic [NUM_BTN-1:0] debLevel
  );
    logic [31:0] w;
    w              = 32'h0000_0000;
    w[NUM_BTN-1:0] = ~debLevel;
    return w;
  endfunction : statusWord

  // Steps a state code up by one and wraps past its top value.
  function automatic logic [UTIL_W-1:0] stepWrap(
    input logic [UTIL_W-1:0] v,
    input logic [UTIL_W-1:0] top
  );
    logic [UTIL_W-1:0] s;
    s = (v >= top) ? '0 : UTIL_W'(v + 1'b1);
    return s;
  endfunction : stepWrap

  assign btnRaw = {pinToggleButtonN, utilButtonN, freqButtonN, resetButtonN};

  // ----------------------------------------------------------------
  // Button conditioning and state stepping
  // ----------------------------------------------------------------
  always_comb begin
    logic [PACE_W-1:0] paceSum;
    logic              doWrite;
    logic [31:0]       wr;
    n       = r;
    press   = '0;
    paceSum = '0;
    doWrite = 1'b0;
    wr      = 32'h0000_0000;

    for (int i = 0; i < NUM_BTN; i++) begin
      // Only the second flip-flop of each synchroniser feeds the debouncer.
      // two-stage sync then stable count
      n.sync1[i] = btnRaw[i];
      n.sync2[i] = r.sync1[i];
      if (r.sync2[i] != r.deb[i]) begin
        if (r.cnt[i] >= DEB_LAST) begin
          n.deb[i] = r.sync2[i];
          n.cnt[i] = '0;
          press[i] = r.deb[i];
        end else begin
          n.cnt[i] = CNT_W'(r.cnt[i] + 1'b1);
        end
      end else begin
        n.cnt[i] = '0;
      end
    end

    // ----------------------------------------------------------------
    // Register write path
    // ----------------------------------------------------------------
    // Software write into the state register, taken once both halves
    // of the write have arrived.
    if (r.awHave && r.wHave && !r.bValid) begin
      n.awHave = 1'b0;
      n.wHave  = 1'b0;
      n.bValid = 1'b1;
      if (regDecode(r.awAddr) == SEL_STATE) begin
        doWrite = 1'b1;
        wr      = r.wData;
        n.bResp = RESP_OKAY;
      end else if (regDecode(r.awAddr) == SEL_STATUS) begin
        n.bResp = RESP_OKAY;
      end else begin
        n.bResp = RESP_SLVERR;
      end
    end
    if (doWrite && r.wStrb[0]) begin
      n.freq = wr[ST_FREQ_LSB +: FREQ_W];
      if (wr[ST_UTIL_LSB +: UTIL_W] <= UTIL_MAX) begin
        n.util = wr[ST_UTIL_LSB +: UTIL_W];
      end
    end
    if (doWrite && r.wStrb[1]) begin
      n.outEn = wr[ST_OUTEN_BIT];
    end

    // ----------------------------------------------------------------
    // State stepping
    // ----------------------------------------------------------------
    // A press in the same cycle as a bus write overrides that field.
    // frequency advance
    if (press[BTN_FREQ]) begin
      n.freq = FREQ_W'(stepWrap(UTIL_W'(r.freq), UTIL_W'(FREQ_MAX)));
    end
    if (press[BTN_UTIL]) begin
      n.util = stepWrap(r.util, UTIL_MAX);
    end
    if (press[BTN_PIN]) begin
      n.outEn = ~r.outEn;
    end
    // The reset button acts on its level and masks writes while held.
    // reset button clears all
    if (!r.deb[BTN_RST]) begin
      n.freq  = FREQ_RST;
      n.util  = UTIL_RST;
      n.outEn = OUTEN_RST;
    end

    // ----------------------------------------------------------------
    // Load pacing
    // ----------------------------------------------------------------
    // Full rate carries every cycle; the remainder stays in the sum.
    // pace accumulator sets toggle rate
    paceSum   = PACE_W'({1'b0, r.pace}) + PACE_STEP[r.freq];
    n.pace    = paceSum[PACE_W-2:0];
    n.paceHit = paceSum[PACE_W-1];

    // ----------------------------------------------------------------
    // Bus channel handshakes
    // ----------------------------------------------------------------
    // Write address and data channels, taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      n.awHave = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.wHave = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    if (r.bValid && s_axi_bready) begin
      n.bValid = 1'b0;
    end

    // Read channel: data one cycle after the address is taken.
    if (s_axi_arvalid && s_axi_arready) begin
      n.rValid = 1'b1;
      n.rData  = 32'h0000_0000;
      n.rResp  = RESP_OKAY;
      if (regDecode(s_axi_araddr) == SEL_STATE) begin
        n.rData = stateWord(r.freq, r.util, r.outEn);
      end else if (regDecode(s_axi_araddr) == SEL_STATUS) begin
        n.rData = statusWord(r.deb);
      end else begin
        n.rResp = RESP_SLVERR;
      end
    end else if (r.rValid && s_axi_rready) begin
      n.rValid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // single clock domain
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r       <= '0;
      r.sync1 <= '1;
      r.sync2 <= '1;
      r.deb   <= '1;
      r.freq  <= FREQ_RST;
      r.util  <= UTIL_RST;
      r.outEn <= OUTEN_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Replicated load
  // ----------------------------------------------------------------
  // Units above the resource state neither advance nor drive their pins.
  // eight pins per resource step
  always_comb begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      unitOn[u] = (UTIL_W'(u) <= r.util);
    end
  end

  for (genvar g = 0; g < NUM_UNITS; g++) begin : gLoad
    pst_load_unit #(
      .Seed (16'(16'h1d3 * (g + 1)))
    ) uUnit (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .advance  (r.paceHit && unitOn[g]),
      .drive    (r.outEn && unitOn[g]),
      .pinData  (loadPins[g*PINS_PER_UNIT +: PINS_PER_UNIT])
    );
  end

  // ----------------------------------------------------------------
  // Indicators and bus outputs
  // ----------------------------------------------------------------
  // frequency code on two LEDs
  assign freqIndicatorBit0 = r.freq[0];
  assign freqIndicatorBit1 = r.freq[1];
  assign utilIndicator     = r.util;
  assign pinToggleLampN    = ~r.outEn;

  // Ready stays low while a write awaits its answer: one write at a time.
  assign s_axi_awready = !r.awHave && !r.bValid;
  assign s_axi_wready  = !r.wHave && !r.bValid;
  assign s_axi_bvalid  = r.bValid;
  assign s_axi_bresp   = r.bResp;
  assign s_axi_arready = !r.rValid;
  assign s_axi_rvalid  = r.rValid;
  assign s_axi_rdata   = r.rData;
  assign s_axi_rresp   = r.rResp;

endmodule : pst_stepper

/* File: tb/pst_stepper_properties.sv */
// Purpose: Port checker for the power state stepper.
// Assumes: Bound to pst_stepper; one clock domain.
// Notes:   Step checks skip cycles just after a register write.
`timescale 1ns/1ps
module pst_stepper_properties
  import pst_pkg::*;
(
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                rst_n,
  // Indicators and pins
  input wire logic                freqIndicatorBit0,
  input wire logic                freqIndicatorBit1,
  input wire logic [UTIL_W-1:0]   utilIndicator,
  input wire logic                pinToggleLampN,
  input wire logic [NUM_PINS-1:0] loadPins,
  // Register bus
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata
);
  logic [1:0] fq;
  logic [1:0] wrAge_r;

  assign fq = {freqIndicatorBit1, freqIndicatorBit0};

  // Counts cycles since the last write so that steps are told apart.
  always_ff @(posedge core_clk) begin
    if (!rst_n || (s_axi_wvalid && s_axi_wready))
      wrAge_r <= 2'h0;
    else if (wrAge_r != 2'h3)
      wrAge_r <= wrAge_r + 2'h1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  freq_step_a: assert property (
    wrAge_r == 2'h3 && $changed(fq) |->
      (fq == $past(fq) + 2'h1) || (fq == 2'h0)) else $error("bad freq step");
  util_step_a: assert property (
    wrAge_r == 2'h3 && $changed(utilIndicator) |->
      (utilIndicator == $past(utilIndicator) + 5'h01) ||
      (utilIndicator == 5'h00)) else $error("bad util step");
  util_range_a: assert property (
    utilIndicator <= UTIL_MAX) else $error("util code above top");
  lamp_off_pins_a: assert property (
    pinToggleLampN |=> loadPins == '0) else $error("pins move while off");
  unused_pins_a: assert property (
    1'b1 |=> (loadPins >> (32'($past(utilIndicator)) * 8 + 8)) == '0)
    else $error("pin above range driven");
  write_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
      ##[1:2] s_axi_bvalid) else $error("write answer late");
  read_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  aw_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("address taken too early");

  top_freq_c: cover property (fq == FREQ_MAX);
  top_util_c: cover property (utilIndicator == UTIL_MAX);
  lamp_on_c:  cover property (!pinToggleLampN);
  mid_rate_c: cover property (fq == 2'h2 && !pinToggleLampN);
endmodule : pst_stepper_properties

bind pst_stepper pst_stepper_properties chk (
  .core_clk, .rst_n, .freqIndicatorBit0, .freqIndicatorBit1,
  .utilIndicator, .pinToggleLampN, .loadPins, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

/* File: tb/pst_button_model.sv */
// Purpose: Push buttons in front of the stepper.
// Assumes: Buttons idle high and are pulled low while pressed.
// Notes:   A press shorter than the debounce time acts as a glitch.
`timescale 1ns/1ps
module pst_button_model (
  // Clock
  input wire logic core_clk,
  // Buttons
  output logic     resetButtonN,
  output logic     freqButtonN,
  output logic     utilButtonN,
  output logic     pinToggleButtonN
);
  logic [3:0] btnN_r = 4'hf;

  assign {pinToggleButtonN, utilButtonN, freqButtonN, resetButtonN} = btnN_r;

  // Holds one button low, releases it and lets the debouncer settle.
  task automatic press(input int idx, input int len);
    @(posedge core_clk);
    btnN_r <= btnN_r & ~(4'h1 << idx);
    repeat (len) @(posedge core_clk);
    btnN_r <= 4'hf;
    repeat (16) @(posedge core_clk);
  endtask : press
endmodule : pst_button_model

/* File: tb/test_power_state_stepper.sv */
// Purpose: Self-checking bench for the power state stepper.
// Assumes: Debounce shortened to 4 cycles.
// Notes:   Bus answers are sampled at the falling edge before each take.
`timescale 1ns/1ps
module test_power_state_stepper;
  import pst_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic resetButtonN, freqButtonN, utilButtonN, pinToggleButtonN;
  logic freqIndicatorBit0, freqIndicatorBit1, pinToggleLampN;
  logic [UTIL_W-1:0] utilIndicator;
  logic [NUM_PINS-1:0] loadPins, p0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int errors = 0, totalChecks = 0, cycles = 0, i;

  always #12.5 core_clk = ~core_clk;

  pst_button_model btn (.core_clk, .resetButtonN, .freqButtonN,
                        .utilButtonN, .pinToggleButtonN);
  pst_stepper #(.DebounceCycles(4)) uut (
    .core_clk, .rst_n, .resetButtonN, .freqButtonN, .utilButtonN,
    .pinToggleButtonN, .freqIndicatorBit0, .freqIndicatorBit1,
    .utilIndicator, .pinToggleLampN, .loadPins, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);

  task automatic summarize();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      $display("Error run length expected below 20000 seen %0d", cycles);
      errors++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic axiWrite(input logic [3:0] a, input logic [31:0] v);
    logic aT = 1'b0, wT = 1'b0, bT = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bT) begin
      @(negedge core_clk);
      aT = s_axi_awvalid && s_axi_awready;
      wT = s_axi_wvalid && s_axi_wready;
      bT = s_axi_bvalid;
      if (bT) check("bresp", RESP_OKAY, s_axi_bresp);
      @(posedge core_clk);
      if (aT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [3:0] a, output logic [31:0] v,
                         output logic [1:0] rs);
    logic aT = 1'b0, rT = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rT) begin
      @(negedge core_clk);
      aT = s_axi_arvalid && s_axi_arready;
      rT = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge core_clk);
      if (aT) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axiRead

  task automatic expectState(input logic [1:0] f, input logic [4:0] u,
                             input logic o);
    axiRead(REG_STATE, d, r);
    check("state", {19'h0, o, 3'h0, u, 2'h0, f}, d & 32'h000011f3);
    check("freq leds", 32'(f), {freqIndicatorBit1, freqIndicatorBit0});
    check("util leds", 32'(u), utilIndicator);
    check("lamp", 32'(!o), pinToggleLampN);
  endtask : expectState

  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    expectState(2'h0, 5'h00, 1'b0);
    axiRead(REG_STATUS, d, r);
    check("status", 32'h0, d & 32'hf);
    for (i = 1; i <= 4; i++) begin
      btn.press(BTN_FREQ, 12);
      expectState(2'(i), 5'h00, 1'b0);
    end
    btn.press(BTN_FREQ, 2);
    expectState(2'h0, 5'h00, 1'b0);
    axiWrite(REG_STATE, 32'h120);
    btn.press(BTN_UTIL, 12);
    expectState(2'h0, 5'h13, 1'b0);
    btn.press(BTN_UTIL, 12);
    expectState(2'h0, 5'h00, 1'b0);
    axiWrite(REG_STATE, 32'h013);
    btn.press(BTN_PIN, 12);
    expectState(2'h3, 5'h01, 1'b1);
    @(negedge core_clk);
    p0 = loadPins;
    repeat (3) @(negedge core_clk);
    check("unused pins", 32'h0, 32'(|loadPins[159:16]));
    check("pins move", 32'h1, 32'(loadPins[15:0] !== p0[15:0]));
    axiWrite(REG_STATE, 32'h1010);
    repeat (3) @(negedge core_clk);
    p0 = loadPins;
    repeat (5) @(negedge core_clk);
    check("pins stopped", 32'(p0[15:0]), loadPins[15:0]);
    btn.press(BTN_PIN, 12);
    expectState(2'h0, 5'h01, 1'b0);
    check("pins off", 32'h0, 32'(|loadPins));
    s_axi_wstrb <= 4'h2;
    axiWrite(REG_STATE, 32'h1032);
    expectState(2'h0, 5'h01, 1'b1);
    s_axi_wstrb <= 4'hf;
    axiWrite(REG_STATE, 32'h1032);
    @(negedge core_clk);
    p0 = loadPins;
    repeat (3) @(negedge core_clk);
    check("mid pins", 32'h1, 32'(loadPins[31:0] !== p0[31:0]));
    check("unused pins", 32'h0, 32'(|loadPins[159:32]));
    btn.press(BTN_RST, 12);
    expectState(2'h0, 5'h00, 1'b0);
    axiRead(4'h8, d, r);
    check("unmapped resp", 32'(RESP_SLVERR), r);
    check("unmapped data", 32'h0, d);
    summarize();
  end
endmodule : test_power_state_stepper
